// ### wev_event_logic.sv
// Operation
// - power button debounced over 16 ms before use or report
// - button actions start at debounced press, regardless of release
// - press in S0 raises SMI or config interrupt per route select
// - press in S1 to S5 is a wake event toward S0
// - in G3 a press is neither latched nor detected
// - button held 4 s in S0 forces soft-off S5
// - forced soft-off waits for no processor or subsystem response
// - readable level bit shows debounced button state
// - override timer counts only in S0
// - ring in S0 gives break-event interrupt, never wake
// - ring in S1 to S5 wakes only when ring wake enabled
// - ring indicate passes with no filtering or debounce
// - falling PME edge gives SMI, config interrupt, or optional wake
// - rising PME edge gives no event
// - graphics busy at C3 entry sets bus master status
// - graphics busy again within C3 is a break event
// - cpu power good held through performance transitions
// - cpu power good held during S1
// - mux select drives external regulator code multiplexer
// - alternate access mode for save and restore of legacy registers
module wev_event_logic (
  // clock and reset
  input  wire logic                  SYS_CLK,
  input  wire logic                  RST_N,
  // register bus
  input  wire wev_pkg::wev_apb_req_t APB_REQ,
  output wev_pkg::wev_apb_rsp_t      APB_RSP,
  // system state from sleep machine
  input  wire logic [2:0]            SLEEP_STATE,
  input  wire logic                  C3_ACTIVE,
  input  wire logic                  PERF_TRANSITION,
  // event pins
  input  wire logic                  POWER_BUTTON_N,
  input  wire logic                  RING_INDICATE_N,
  input  wire logic                  PCI_PME_N,
  input  wire logic                  GRAPHICS_BUSY_N,
  // regulator side
  input  wire logic                  REGULATOR_OUTPUT_GOOD,
  output logic                       VR_CODE_MUX_SELECT_N,
  output logic                       CPU_POWER_GOOD,
  // event outputs
  output wev_pkg::wev_evt_t          EVENTS,
  output logic                       SYSTEM_MGMT_INTERRUPT_N,
  output logic                       ALT_ACCESS_MODE
);

  typedef struct packed {
    logic [4:0]  ctrl;
    logic [4:0]  events;
    logic        bm_status;
    logic        btn_level;
    logic        btn_raw_prev;
    logic [18:0] deb_cnt;
    logic [26:0] ovr_cnt;
    logic        ovr_done;
    logic        pme_prev;
    logic        gfx_prev;
    logic        c3_prev;
    logic        cpu_good;
    wev_pkg::wev_evt_t evt;
    logic        smi_n;
    logic [31:0] rdata;
  } wev_state_t;

  wev_state_t state;
  wev_state_t next_state;

  logic        acc;
  logic        in_sleep;
  logic        in_s0;
  logic        press_edge;
  logic        pme_fall;
  logic        ring_act;
  logic        gfx_act;

  // register write strobe test
  function automatic logic wr_hit(input wev_pkg::wev_apb_req_t r, input logic [11:0] a);
    wr_hit = r.psel && r.penable && r.pwrite && (r.paddr == a);
  endfunction : wr_hit

  ////////////////////////////////////////////////////////////////////////////
  // decoded conditions
  assign acc        = APB_REQ.psel && APB_REQ.penable;
  assign in_s0      = (SLEEP_STATE == wev_pkg::ST_S0);
  assign in_sleep   = (SLEEP_STATE >= wev_pkg::ST_S1) && (SLEEP_STATE <= wev_pkg::ST_S5);
  assign ring_act   = !RING_INDICATE_N;
  assign gfx_act    = !GRAPHICS_BUSY_N;
  assign pme_fall   = state.pme_prev && !PCI_PME_N;

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb
  begin
    next_state = state;
    next_state.evt = '0;
    next_state.smi_n = 1'b1;
    next_state.btn_raw_prev = !POWER_BUTTON_N;
    next_state.pme_prev = PCI_PME_N;
    next_state.gfx_prev = gfx_act;
    next_state.c3_prev = C3_ACTIVE;

    // register writes first, so hardware sets below win over clears
    if (wr_hit(APB_REQ, wev_pkg::CTRL_ADDR))
      next_state.ctrl = APB_REQ.pwdata[4:0];
    if (wr_hit(APB_REQ, wev_pkg::STATUS_ADDR) && APB_REQ.pwdata[wev_pkg::STAT_BM_BIT])
      next_state.bm_status = 1'b0;
    if (wr_hit(APB_REQ, wev_pkg::EVENT_ADDR))
      next_state.events = state.events & ~APB_REQ.pwdata[4:0];

    // debounce: restart on any change, accept after full interval
    if (SLEEP_STATE == wev_pkg::ST_G3)
    begin
      next_state.deb_cnt = '0;
      next_state.btn_level = 1'b0;
    end
    else if ((!POWER_BUTTON_N) != state.btn_raw_prev)
      next_state.deb_cnt = '0;
    else if (state.deb_cnt < 19'(wev_pkg::DEBOUNCE_CYCLES - 1))
      next_state.deb_cnt = state.deb_cnt + 19'h00001;
    else
      next_state.btn_level = state.btn_raw_prev;

    // debounced level rising marks a press
    press_edge = next_state.btn_level && !state.btn_level;

    // press actions fire on debounced edge
    if (press_edge)
    begin
      if (in_s0)
      begin
        next_state.events[wev_pkg::EV_BTN_BIT] = 1'b1;
        if (state.ctrl[wev_pkg::CTRL_ROUTE_BIT])
          next_state.evt.cfg_int = 1'b1;
        else
          next_state.smi_n = 1'b0;
      end
      else if (in_sleep)
        next_state.evt.wake = 1'b1;
    end

    // override timer, S0 only, held press
    if (in_s0 && state.btn_level && !state.ovr_done)
    begin
      if (state.ovr_cnt < 27'(wev_pkg::OVERRIDE_CYCLES - 1))
        next_state.ovr_cnt = state.ovr_cnt + 27'h0000001;
      else
      begin
        next_state.evt.force_off = 1'b1;
        next_state.ovr_done = 1'b1;
        next_state.events[wev_pkg::EV_OVR_BIT] = 1'b1;
      end
    end
    else if (!state.btn_level || !in_s0)
    begin
      next_state.ovr_cnt = '0;
      next_state.ovr_done = 1'b0;
    end

    // ring indicate
    if (ring_act && in_s0)
    begin
      next_state.evt.break_ev = 1'b1;
      next_state.evt.cfg_int = 1'b1;
      next_state.events[wev_pkg::EV_RING_BIT] = 1'b1;
    end
    else if (ring_act && in_sleep && state.ctrl[wev_pkg::CTRL_RING_BIT])
    begin
      next_state.evt.wake = 1'b1;
      next_state.events[wev_pkg::EV_RING_BIT] = 1'b1;
    end

    // pci power management event, falling edge only
    if (pme_fall)
    begin
      next_state.events[wev_pkg::EV_PME_BIT] = 1'b1;
      if (in_sleep && state.ctrl[wev_pkg::CTRL_PME_WK_BIT])
        next_state.evt.wake = 1'b1;
      else if (state.ctrl[wev_pkg::CTRL_ROUTE_BIT])
        next_state.evt.cfg_int = 1'b1;
      else
        next_state.smi_n = 1'b0;
    end

    // graphics busy around C3
    if (C3_ACTIVE && !state.c3_prev && gfx_act)
      next_state.bm_status = 1'b1;
    if (C3_ACTIVE && state.c3_prev && gfx_act && !state.gfx_prev)
    begin
      next_state.evt.break_ev = 1'b1;
      next_state.events[wev_pkg::EV_BREAK_BIT] = 1'b1;
    end

    // cpu power good: regulator good, held in transitions and S1
    if (PERF_TRANSITION && state.cpu_good)
      next_state.cpu_good = 1'b1;
    else if (SLEEP_STATE == wev_pkg::ST_S1 && state.cpu_good)
      next_state.cpu_good = 1'b1;
    else
      next_state.cpu_good = REGULATOR_OUTPUT_GOOD && (SLEEP_STATE <= wev_pkg::ST_S1);

    // read data registered in setup phase
    next_state.rdata = '0;
    unique case (APB_REQ.paddr)
      wev_pkg::CTRL_ADDR:   next_state.rdata[4:0] = state.ctrl;
      wev_pkg::STATUS_ADDR: next_state.rdata[1:0] = {state.bm_status, state.btn_level};
      wev_pkg::EVENT_ADDR:  next_state.rdata[4:0] = state.events;
      wev_pkg::ALT_ADDR:    next_state.rdata[0]   = state.ctrl[wev_pkg::CTRL_ALT_BIT];
      default:              next_state.rdata = '0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
    begin
      state <= '0;
      state.ctrl <= wev_pkg::CTRL_RESET;
      state.smi_n <= 1'b1;
      state.pme_prev <= 1'b1;
    end
    else
      state <= next_state;
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign APB_RSP.pready  = 1'b1;
  assign APB_RSP.pslverr = acc && (APB_REQ.paddr > wev_pkg::ALT_ADDR);
  assign APB_RSP.prdata  = state.rdata;
  assign EVENTS                  = state.evt;
  assign SYSTEM_MGMT_INTERRUPT_N = state.smi_n;
  assign CPU_POWER_GOOD          = state.cpu_good;
  assign VR_CODE_MUX_SELECT_N    = !state.ctrl[wev_pkg::CTRL_SEL_BIT];
  assign ALT_ACCESS_MODE         = state.ctrl[wev_pkg::CTRL_ALT_BIT];

endmodule : wev_event_logic

// ### wev_pkg.sv
package wev_pkg;

  // clock rate and debounce / override times
  localparam int unsigned CLK_HZ          = 25000000;
  localparam int unsigned DEBOUNCE_MS     = 16;
  localparam int unsigned OVERRIDE_S      = 4;
  localparam int unsigned DEBOUNCE_CYCLES = CLK_HZ / 1000 * DEBOUNCE_MS;
  localparam int unsigned OVERRIDE_CYCLES = CLK_HZ * OVERRIDE_S;

  // register byte offsets
  localparam logic [11:0] CTRL_ADDR   = 12'h000;
  localparam logic [11:0] STATUS_ADDR = 12'h004;
  localparam logic [11:0] EVENT_ADDR  = 12'h008;
  localparam logic [11:0] ALT_ADDR    = 12'h00c;

  // control register fields
  localparam int unsigned CTRL_ROUTE_BIT  = 0;
  localparam int unsigned CTRL_RING_BIT   = 1;
  localparam int unsigned CTRL_PME_WK_BIT = 2;
  localparam int unsigned CTRL_ALT_BIT    = 3;
  localparam int unsigned CTRL_SEL_BIT    = 4;
  localparam logic [4:0]  CTRL_RESET      = 5'h00;

  // status register fields
  localparam int unsigned STAT_LEVEL_BIT = 0;
  localparam int unsigned STAT_BM_BIT    = 1;

  // event register fields (write one to clear)
  localparam int unsigned EV_BTN_BIT   = 0;
  localparam int unsigned EV_RING_BIT  = 1;
  localparam int unsigned EV_PME_BIT   = 2;
  localparam int unsigned EV_BREAK_BIT = 3;
  localparam int unsigned EV_OVR_BIT   = 4;

  // system sleep states as seen by this block
  localparam logic [2:0] ST_S0 = 3'h0;
  localparam logic [2:0] ST_S1 = 3'h1;
  localparam logic [2:0] ST_S4 = 3'h4;
  localparam logic [2:0] ST_S5 = 3'h5;
  localparam logic [2:0] ST_G3 = 3'h7;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } wev_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } wev_apb_rsp_t;

  typedef struct packed {
    logic wake;
    logic smi_pulse;
    logic cfg_int;
    logic break_ev;
    logic force_off;
  } wev_evt_t;

endpackage : wev_pkg

// ### wev_event_logic_properties.sv
module wev_chk (
  // watched ports
  input wire logic                  SYS_CLK,
  input wire logic                  RST_N,
  input wire wev_pkg::wev_apb_req_t APB_REQ,
  input wire logic [2:0]            SLEEP_STATE,
  input wire logic                  C3_ACTIVE,
  input wire logic                  PERF_TRANSITION,
  input wire logic                  RING_INDICATE_N,
  input wire logic                  PCI_PME_N,
  input wire logic                  GRAPHICS_BUSY_N,
  input wire logic                  CPU_POWER_GOOD,
  input wire logic                  VR_CODE_MUX_SELECT_N,
  input wire wev_pkg::wev_evt_t     EVENTS,
  input wire logic                  SYSTEM_MGMT_INTERRUPT_N,
  input wire logic                  ALT_ACCESS_MODE
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  // completed write to the control word
  wire wr_ctrl = APB_REQ.psel && APB_REQ.penable && APB_REQ.pwrite
                 && APB_REQ.paddr == wev_pkg::CTRL_ADDR;
  ////////////////////////////////////////////////////////////////
  chk_mux_select: assert property (wr_ctrl && APB_REQ.pwdata[4]
    |-> ##[1:2] !VR_CODE_MUX_SELECT_N) else $error("mux select not driven");
  chk_alt_mode: assert property (wr_ctrl && APB_REQ.pwdata[3]
    |-> ##[1:2] ALT_ACCESS_MODE) else $error("alt mode not entered");
  chk_s0_no_wake: assert property ((SLEEP_STATE == wev_pkg::ST_S0)[*4]
    |=> !EVENTS.wake) else $error("wake while working");
  chk_g3_quiet: assert property ((SLEEP_STATE == wev_pkg::ST_G3)[*4]
    |=> !EVENTS.wake) else $error("wake without power");
  chk_pme_fall: assert property ($fell(PCI_PME_N)
    |-> ##[1:3] (EVENTS.cfg_int || !SYSTEM_MGMT_INTERRUPT_N || EVENTS.wake))
    else $error("pme fall gave no event");
  chk_pme_rise: assert property ($rose(PCI_PME_N)
    |=> (!EVENTS.cfg_int && !EVENTS.wake)[*3]) else $error("pme rise gave event");
  chk_cpg_perf: assert property (CPU_POWER_GOOD && PERF_TRANSITION
    && SLEEP_STATE == wev_pkg::ST_S0 |=> CPU_POWER_GOOD) else $error("cpg dropped");
  chk_cpg_sleep: assert property (CPU_POWER_GOOD && SLEEP_STATE == wev_pkg::ST_S1
    |=> CPU_POWER_GOOD) else $error("cpg dropped in S1");
  chk_busy_break: assert property ($fell(GRAPHICS_BUSY_N) && C3_ACTIVE
    && $past(C3_ACTIVE) |-> ##[1:3] EVENTS.break_ev) else $error("no break event");
  chk_ring_break: assert property (!RING_INDICATE_N
    && SLEEP_STATE == wev_pkg::ST_S0 |=> EVENTS.break_ev) else $error("ring gave no break");
endmodule : wev_chk
bind wev_event_logic wev_chk u_chk (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .APB_REQ(APB_REQ),
  .SLEEP_STATE(SLEEP_STATE), .C3_ACTIVE(C3_ACTIVE), .PERF_TRANSITION(PERF_TRANSITION),
  .RING_INDICATE_N(RING_INDICATE_N),
  .PCI_PME_N(PCI_PME_N), .GRAPHICS_BUSY_N(GRAPHICS_BUSY_N), .EVENTS(EVENTS),
  .CPU_POWER_GOOD(CPU_POWER_GOOD), .VR_CODE_MUX_SELECT_N(VR_CODE_MUX_SELECT_N),
  .SYSTEM_MGMT_INTERRUPT_N(SYSTEM_MGMT_INTERRUPT_N), .ALT_ACCESS_MODE(ALT_ACCESS_MODE));

// ### wev_regulator_model.sv
module wev_regulator_model #(
  parameter int unsigned SETTLE = 8
) (
  // board control
  input  wire logic clk,
  input  wire logic enable,
  input  wire logic code_sel_n,
  // status to block
  output logic      good
);
  logic [7:0] wait_cnt   = 8'h00;
  logic       last_sel_n = 1'b1;
  // restart settling when switched off or the code changes
  always_ff @(posedge clk)
  begin
    last_sel_n <= code_sel_n;
    if (!enable || code_sel_n != last_sel_n)
      wait_cnt <= 8'(SETTLE);
    else if (wait_cnt != 8'h00)
      wait_cnt <= wait_cnt - 8'h01;
  end
  // good only when on and settled
  assign good = enable && wait_cnt == 8'h00;
endmodule : wev_regulator_model

// ### testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic                  sys_clk = 1'b0;
  logic                  rst_n   = 1'b0;
  wev_pkg::wev_apb_req_t req     = '0;
  wev_pkg::wev_apb_rsp_t rsp;
  wev_pkg::wev_evt_t     evt;
  logic [2:0]            state   = 3'h0;
  logic [3:0]            pins    = 4'hf;
  logic                  c3 = 1'b0, perf = 1'b0, vr_en = 1'b0;
  logic                  vr_good, mux_n, cpg, smi_n, alt;
  int                    n_brk = 0;
  logic [32:0]           exp_q[$];
  int                    n_errors = 0, n_tests = 0, n_wake = 0, n_cfg = 0, n_smi = 0;
  int                    seed = 32'h94c9;
  logic [31:0]           rnd;
  always #20 sys_clk = ~sys_clk;
  wev_event_logic DUT (.SYS_CLK(sys_clk), .RST_N(rst_n), .APB_REQ(req), .APB_RSP(rsp),
    .SLEEP_STATE(state), .C3_ACTIVE(c3), .PERF_TRANSITION(perf), .POWER_BUTTON_N(pins[3]),
    .RING_INDICATE_N(pins[0]), .PCI_PME_N(pins[1]), .GRAPHICS_BUSY_N(pins[2]),
    .REGULATOR_OUTPUT_GOOD(vr_good), .VR_CODE_MUX_SELECT_N(mux_n), .CPU_POWER_GOOD(cpg),
    .EVENTS(evt), .SYSTEM_MGMT_INTERRUPT_N(smi_n), .ALT_ACCESS_MODE(alt));
  wev_regulator_model u_vr (.clk(sys_clk), .enable(vr_en), .code_sel_n(mux_n), .good(vr_good));
  ////////////////////////////////////////////////////////////////
  task automatic check(input logic [32:0] seen, input logic [32:0] want);
    n_tests++;
    if (seen !== want)
    begin
      n_errors++;
      $display("[ERR] %0t got %h want %h", $time, seen, want);
    end
  endtask : check
  // one apb transfer, reads note their expectation
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [32:0] want);
    @(posedge sys_clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    if (!wr)
      exp_q.push_back(want);
    @(posedge sys_clk);
    req.penable <= 1'b1;
    @(posedge sys_clk);
    while (rsp.pready !== 1'b1)
      @(posedge sys_clk);
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb
  // drive one event pin low, then release it
  task automatic pulse(input int i);
    @(posedge sys_clk);
    pins[i] <= 1'b0;
    repeat (6) @(posedge sys_clk);
    pins[i] <= 1'b1;
    repeat (6) @(posedge sys_clk);
  endtask : pulse
  task automatic tally_and_finish();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish
  ////////////////////////////////////////////////////////////////
  // compare completed reads, count event pulses
  always @(posedge sys_clk)
  begin
    if (req.psel && req.penable && !req.pwrite && rsp.pready === 1'b1)
      check({rsp.pslverr, rsp.prdata}, exp_q.pop_front());
    n_wake += (evt.wake === 1'b1);
    n_cfg += (evt.cfg_int === 1'b1);
    n_smi += (smi_n === 1'b0);
    n_brk += (evt.break_ev === 1'b1);
  end
  initial
  begin
    #(40 * 20000);
    n_errors++;
    tally_and_finish();
  end
  // main sequence
  initial
  begin
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    vr_en <= 1'b1;
    for (int a = 0; a < 16; a += 4)
      apb(1'b0, 12'(a), 32'h0, 33'h0);
    apb(1'b0, 12'h010, 32'h0, 33'h1_0000_0000);
    rnd = $random(seed) & 32'h1f;
    apb(1'b1, wev_pkg::CTRL_ADDR, rnd, 33'h0);
    apb(1'b0, wev_pkg::CTRL_ADDR, 32'h0, {1'b0, rnd});
    state <= 3'h3;
    for (int b = 0; b < 3; b++)
    begin
      apb(1'b1, wev_pkg::CTRL_ADDR, 32'(2 * b), 33'h0);
      n_wake = 0;
      pulse(0);
      check(33'(n_wake > 0), 33'(b == 1));
      n_wake = 0;
      pulse(1);
      check(33'(n_wake > 0), 33'(b == 2));
    end
    state <= wev_pkg::ST_S0;
    for (int r = 0; r < 2; r++)
    begin
      apb(1'b1, wev_pkg::CTRL_ADDR, 32'(r), 33'h0);
      apb(1'b1, wev_pkg::EVENT_ADDR, 32'h1f, 33'h0);
      {n_cfg, n_smi} = '0;
      pulse(1);
      check(33'(n_cfg + 2 * n_smi), r ? 33'h1 : 33'h2);
      apb(1'b0, wev_pkg::EVENT_ADDR, 32'h0, 33'h4);
    end
    n_wake = 0;
    n_brk = 0;
    pulse(0);
    check(33'(n_wake), 33'h0);
    check(33'(n_brk > 0), 33'h1);
    // short button glitch: no action, level stays released
    {n_cfg, n_smi} = '0;
    pulse(3);
    check(33'(n_cfg + n_smi), 33'h0);
    apb(1'b0, wev_pkg::STATUS_ADDR, 32'h0, 33'h0);
    // busy without any C3 entry leaves status clear
    pulse(2);
    apb(1'b0, wev_pkg::STATUS_ADDR, 32'h0, 33'h0);
    // busy held while C3 is entered sets status
    pins[2] <= 1'b0;
    repeat (2) @(posedge sys_clk);
    c3 <= 1'b1;
    repeat (2) @(posedge sys_clk);
    pins[2] <= 1'b1;
    apb(1'b0, wev_pkg::STATUS_ADDR, 32'h0, 33'h2);
    apb(1'b1, wev_pkg::STATUS_ADDR, 32'h2, 33'h0);
    apb(1'b0, wev_pkg::STATUS_ADDR, 32'h0, 33'h0);
    apb(1'b1, wev_pkg::EVENT_ADDR, 32'h1f, 33'h0);
    pulse(2);
    apb(1'b0, wev_pkg::EVENT_ADDR, 32'h0, 33'h8);
    c3 <= 1'b0;
    check(33'(cpg), 33'h1);
    perf <= 1'b1;
    apb(1'b1, wev_pkg::CTRL_ADDR, 32'h18, 33'h0);
    repeat (3) @(posedge sys_clk);
    check(33'(cpg), 33'h1);
    check(33'(mux_n), 33'h0);
    check(33'(alt), 33'h1);
    apb(1'b0, wev_pkg::ALT_ADDR, 32'h0, 33'h1);
    perf <= 1'b0;
    state <= wev_pkg::ST_S1;
    vr_en <= 1'b0;
    repeat (4) @(posedge sys_clk);
    check(33'(cpg), 33'h1);
    state <= wev_pkg::ST_G3;
    n_wake = 0;
    pulse(1);
    pulse(3);
    check(33'(n_wake), 33'h0);
    state <= wev_pkg::ST_S0;
    repeat (4) @(posedge sys_clk);
    check(33'(cpg), 33'h0);
    tally_and_finish();
  end
endmodule : testbench
